//--- hw/ilpc_top.v
// interrupt controller with power-down, idle and slowed idle control
//
// Notes on behaviour
// - eleven sources plus reset: pins, timer, byte engine, serial ports, power-down
// - fixed vectors: reset 0000, power-down 002C, others 0004 to 0028 by priority
// - every level maskable except reset and power-down
// - general and serial-shared pins edge or level; level pins level; edge pin edge
// - requests ANDed with mask, highest priority survivor selected
// - all interrupts blocked one cycle after a mask write; transfers unaffected
// - control register picks nested or sequential service and edge/level modes
// - write-only force/clear register sets or clears pending requests
// - status pushed on entry, popped on return; twelve-deep stack shared with loops
// - global enable and disable override the mask, power-down included
// - after reset global servicing is enabled
// - power-down requested by pin or force bit; edge, non-maskable interrupt
// - wake resumes after 200 input clocks, or 4096 if oscillator stopped
// - context select chooses resume or cleared context after power-down
// - master reset ends power-down
// - power-down acknowledge output high once power-down is entered
// - idle waits for an unmasked interrupt; transfers continue meanwhile
// - slowed idle divides clock by 16, 32, 64 or 128, outputs slowed too
// - slowed idle exit may take up to the divisor count of cycles
// - cycle clock output toggles each cycle outside slowed idle, power-down and wake unless its disable bit is set
// - reconfigured second serial port frame pins take over that port's two interrupt levels
`timescale 1ns/1ps
`default_nettype none
`include "ilpc_defines.vh"
module ilpc_top #(
    parameter NSTACK = `ILPC_NSTACK,
    parameter WAKE_FAST_CYCLES = `ILPC_WAKE_FAST_INPUT_CLOCK * `ILPC_INPUT_CLOCK_NS / `ILPC_PCLK_NS,
    parameter WAKE_XTAL_CYCLES = `ILPC_WAKE_XTAL_INPUT_CLOCK * `ILPC_INPUT_CLOCK_NS / `ILPC_PCLK_NS
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire pin_int_general_n,
    input wire pin_int_level_a_n,
    input wire pin_int_level_b_n,
    input wire pin_int_edge_n,
    input wire serial_shared_int_rx_n,
    input wire serial_shared_int_tx_n,
    input wire powerdown_request_pin_n,
    input wire timer_event,
    input wire byte_transfer_event,
    input wire first_serial_tx_event,
    input wire first_serial_rx_event,
    input wire second_serial_tx_event,
    input wire second_serial_rx_event,
    input wire int_ack,
    input wire int_return,
    input wire seq_push,
    input wire seq_pop,
    input wire [15:0] status_in,
    output reg [15:0] status_out,
    output reg int_req,
    output reg [15:0] int_vector,
    output reg powerdown_ack,
    output reg core_halt,
    output reg core_clk_en,
    output reg context_clear,
    output reg cycle_clock_output
);
    localparam ST_RUN = 3'd0;
    localparam ST_IDLE = 3'd1;
    localparam ST_SIDLE = 3'd2;
    localparam ST_PDOWN = 3'd3;
    localparam ST_WAKE = 3'd4;
    localparam NS = `ILPC_NSRC;

    // pin synchronisers; stage one feeds stage two only
    reg [6:0] sync1, sync2, sync3;
    wire [6:0] pins_n = {powerdown_request_pin_n, serial_shared_int_tx_n, serial_shared_int_rx_n,
                         pin_int_edge_n, pin_int_level_b_n, pin_int_level_a_n, pin_int_general_n};
    wire [6:0] pin_act = ~sync2;
    wire [6:0] pin_fall = sync3 & ~sync2;

    reg [9:0] interrupt_mask_reg;
    reg [4:0] interrupt_control_reg;
    reg [2:0] power_ctrl;
    reg [NS-1:0] pend_edge, in_service;
    reg mask_block, gie;
    reg [2:0] state;
    reg [15:0] wake_cnt;
    reg [7:0] slow_cnt;
    reg [1:0] slow_div;
    reg [15:0] stack_mem [0:NSTACK-1];
    reg [4:0] sp;
    reg stack_err;

    wire apb_done = psel & penable & pready;
    wire apb_wr = apb_done & pwrite;
    wire [7:0] reg_addr = paddr[7:0];
    wire wr_mask = apb_wr & (reg_addr == `ILPC_ADDR_MASK);
    wire wr_fclr = apb_wr & (reg_addr == `ILPC_ADDR_FCLR);
    wire wr_cmd = apb_wr & (reg_addr == `ILPC_ADDR_CMD);
    wire [NS-1:0] force_bits = wr_fclr ? pwdata[NS-1:0] : {NS{1'b0}};
    wire [NS-1:0] clear_bits = wr_fclr ?
        pwdata[`ILPC_FCLR_CLR_LSB+NS-1:`ILPC_FCLR_CLR_LSB] : {NS{1'b0}};

    wire sp2_irq = interrupt_control_reg[`ILPC_CTRL_SP2_IRQ];
    reg [NS-1:0] edge_mode, edge_evt, level_act;
    always @* begin
        edge_mode = {NS{1'b1}};
        edge_mode[`ILPC_SRC_GEN] = interrupt_control_reg[`ILPC_CTRL_GEN_EDGE];
        edge_mode[`ILPC_SRC_LVA] = 1'b0;
        edge_mode[`ILPC_SRC_LVB] = 1'b0;
        edge_mode[`ILPC_SRC_SP1RX] = ~sp2_irq | interrupt_control_reg[`ILPC_CTRL_RX_EDGE];
        edge_mode[`ILPC_SRC_SP1TX] = ~sp2_irq | interrupt_control_reg[`ILPC_CTRL_TX_EDGE];
        edge_evt = {NS{1'b0}};
        edge_evt[`ILPC_SRC_PWD] = pin_fall[6];
        edge_evt[`ILPC_SRC_GEN] = pin_fall[0];
        edge_evt[`ILPC_SRC_EDGE] = pin_fall[3];
        edge_evt[`ILPC_SRC_SP0TX] = first_serial_tx_event;
        edge_evt[`ILPC_SRC_SP0RX] = first_serial_rx_event;
        edge_evt[`ILPC_SRC_BYTE_TRANSFER_ENGINE] = byte_transfer_event;
        edge_evt[`ILPC_SRC_TIMER] = timer_event;
        edge_evt[`ILPC_SRC_SP1TX] = sp2_irq ? pin_fall[5] : second_serial_tx_event;
        edge_evt[`ILPC_SRC_SP1RX] = sp2_irq ? pin_fall[4] : second_serial_rx_event;
        level_act = {NS{1'b0}};
        level_act[`ILPC_SRC_GEN] = pin_act[0];
        level_act[`ILPC_SRC_LVA] = pin_act[1];
        level_act[`ILPC_SRC_LVB] = pin_act[2];
        level_act[`ILPC_SRC_SP1RX] = sp2_irq & pin_act[4];
        level_act[`ILPC_SRC_SP1TX] = sp2_irq & pin_act[5];
    end

    wire [NS-1:0] req_raw = pend_edge | (level_act & ~edge_mode);
    wire [NS-1:0] req_masked = req_raw & {interrupt_mask_reg, 1'b1};

    // low index wins; nesting admits only higher levels
    reg sel_valid, busy_above;
    reg [3:0] sel_idx;
    integer i;
    always @* begin
        sel_valid = 1'b0;
        sel_idx = 4'd0;
        busy_above = 1'b0;
        for (i = 0; i < NS; i = i + 1) begin
            if (in_service[i]) begin
                busy_above = 1'b1;
            end
            if (!sel_valid && req_masked[i] && !busy_above) begin
                sel_valid = 1'b1;
                sel_idx = i[3:0];
            end
        end
        if (!interrupt_control_reg[`ILPC_CTRL_NEST] && (in_service != {NS{1'b0}})) begin
            sel_valid = 1'b0;
        end
    end
    wire req_ok = sel_valid & gie & ~mask_block;
    wire [15:0] sel_vec = (sel_idx == 4'd`ILPC_SRC_PWD) ? `ILPC_VEC_PWD :
        {10'h000, sel_idx, 2'b00};

    wire ack_ok = int_ack & int_req;
    reg [NS-1:0] ack_clr, ret_clr;
    reg ret_found;
    integer k;
    always @* begin
        ack_clr = {NS{1'b0}};
        ret_clr = {NS{1'b0}};
        ret_found = 1'b0;
        if (ack_ok) begin
            ack_clr[sel_idx] = 1'b1;
        end
        for (k = 0; k < NS; k = k + 1) begin
            if (int_return && !ret_found && in_service[k]) begin
                ret_found = 1'b1;
                ret_clr[k] = 1'b1;
            end
        end
    end

    wire [7:0] div_count = `ILPC_SLOW_MIN << slow_div;
    wire slow_tick = (slow_cnt == div_count - 8'h01);
    wire wake_req = sel_valid & ~mask_block;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 7'h7F;
            sync2 <= 7'h7F;
            sync3 <= 7'h7F;
            pend_edge <= {NS{1'b0}};
        end else if (ce) begin
            sync1 <= pins_n;
            sync2 <= sync1;
            sync3 <= sync2;
            // a new event wins over a clear in the same cycle
            pend_edge <= (pend_edge & ~(clear_bits | ack_clr)) | (edge_evt & edge_mode)
                         | force_bits;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask_reg <= `ILPC_MASK_RST;
            interrupt_control_reg <= `ILPC_CTRL_RST;
            power_ctrl <= `ILPC_PWR_RST;
            mask_block <= 1'b0;
            gie <= 1'b1;
        end else if (ce) begin
            mask_block <= wr_mask;
            if (wr_mask) begin
                interrupt_mask_reg <= pwdata[9:0];
            end
            if (apb_wr && reg_addr == `ILPC_ADDR_CTRL) begin
                interrupt_control_reg <= pwdata[4:0];
            end
            if (apb_wr && reg_addr == `ILPC_ADDR_PWR) begin
                power_ctrl <= pwdata[2:0];
            end
            if (wr_cmd && pwdata[`ILPC_CMD_DIS]) begin
                gie <= 1'b0;
            end else if (wr_cmd && pwdata[`ILPC_CMD_ENA]) begin
                gie <= 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_req <= 1'b0;
            int_vector <= `ILPC_VEC_RESET;
            in_service <= {NS{1'b0}};
        end else if (ce) begin
            int_req <= req_ok & ~ack_ok & (state == ST_RUN);
            if (req_ok) begin
                int_vector <= sel_vec;
            end
            in_service <= (in_service & ~ret_clr) | ack_clr;
        end
    end

    wire do_push = ack_ok | seq_push;
    wire do_pop = (int_return | seq_pop) & ~do_push;
    always @(posedge pclk) begin
        if (ce && do_push && sp < NSTACK) begin
            stack_mem[sp[3:0]] <= status_in;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= 5'd0;
            stack_err <= 1'b0;
            status_out <= 16'h0000;
        end else if (ce) begin
            if (do_push) begin
                if (sp < NSTACK) begin
                    sp <= sp + 5'd1;
                end else begin
                    stack_err <= 1'b1;
                end
            end else if (do_pop) begin
                if (sp != 5'd0) begin
                    sp <= sp - 5'd1;
                    status_out <= stack_mem[sp[3:0] - 4'd1];
                end else begin
                    stack_err <= 1'b1;
                end
            end
        end
    end

    // power state machine; presetn alone ends power-down as well
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
            wake_cnt <= 16'h0000;
            slow_cnt <= 8'h00;
            slow_div <= 2'b00;
            powerdown_ack <= 1'b0;
            core_halt <= 1'b0;
            core_clk_en <= 1'b1;
            context_clear <= 1'b0;
        end else if (ce) begin
            context_clear <= 1'b0;
            case (state)
                ST_RUN: begin
                    core_clk_en <= 1'b1;
                    slow_cnt <= 8'h00;
                    if (wr_cmd && pwdata[`ILPC_CMD_PDOWN]) begin
                        state <= ST_PDOWN;
                        powerdown_ack <= 1'b1;
                        core_halt <= 1'b1;
                    end else if (wr_cmd && pwdata[`ILPC_CMD_IDLE]) begin
                        core_halt <= 1'b1;
                        slow_div <= pwdata[`ILPC_CMD_DIV_LSB+1:`ILPC_CMD_DIV_LSB];
                        state <= pwdata[`ILPC_CMD_SLOW] ? ST_SIDLE : ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (req_ok) begin
                        state <= ST_RUN;
                        core_halt <= 1'b0;
                    end
                end
                ST_SIDLE: begin
                    // the slowed core only sees the request on its own tick
                    slow_cnt <= slow_tick ? 8'h00 : slow_cnt + 8'h01;
                    core_clk_en <= slow_tick;
                    if (slow_tick && req_ok) begin
                        state <= ST_RUN;
                        core_halt <= 1'b0;
                        core_clk_en <= 1'b1;
                    end
                end
                ST_PDOWN: begin
                    if (wake_req) begin
                        state <= ST_WAKE;
                        powerdown_ack <= 1'b0;
                        wake_cnt <= power_ctrl[`ILPC_PWR_XTAL] ? WAKE_XTAL_CYCLES[15:0]
                                                               : WAKE_FAST_CYCLES[15:0];
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt <= 16'h0001) begin
                        state <= ST_RUN;
                        core_halt <= 1'b0;
                        context_clear <= power_ctrl[`ILPC_PWR_CTX];
                    end else begin
                        wake_cnt <= wake_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // cycle clock out; stopped in power-down, slowed in slowed idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_clock_output <= 1'b0;
        end else if (ce) begin
            if (power_ctrl[`ILPC_PWR_CKODIS] || state == ST_PDOWN || state == ST_WAKE) begin
                cycle_clock_output <= 1'b0;
            end else if (state != ST_SIDLE || slow_tick) begin
                cycle_clock_output <= ~cycle_clock_output;
            end
        end
    end

    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (reg_addr)
            `ILPC_ADDR_MASK: rd_mux[9:0] = interrupt_mask_reg;
            `ILPC_ADDR_CTRL: rd_mux[4:0] = interrupt_control_reg;
            `ILPC_ADDR_FCLR: rd_mux = 32'h00000000;
            `ILPC_ADDR_PEND: rd_mux[NS-1:0] = req_raw;
            `ILPC_ADDR_CMD: rd_mux[0] = gie;
            `ILPC_ADDR_PWR: rd_mux[2:0] = power_ctrl;
            `ILPC_ADDR_STAT: rd_mux = {9'h000, stack_err, sp, in_service, 1'b0, gie, 1'b0, state};
            default: rd_err = 1'b1;
        endcase
        if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & rd_err;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rd_err ? 32'h00000000 : rd_mux;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/ilpc_defines.vh
// constants for the interrupt and low power controller
`ifndef ILPC_DEFINES_VH
`define ILPC_DEFINES_VH
`define ILPC_NSRC 11
`define ILPC_NSTACK 12
`define ILPC_PCLK_NS 10
`define ILPC_INPUT_CLOCK_NS 20
`define ILPC_WAKE_FAST_INPUT_CLOCK 200
`define ILPC_WAKE_XTAL_INPUT_CLOCK 4096
`define ILPC_ADDR_MASK 8'h00
`define ILPC_ADDR_CTRL 8'h04
`define ILPC_ADDR_FCLR 8'h08
`define ILPC_ADDR_PEND 8'h0C
`define ILPC_ADDR_CMD 8'h10
`define ILPC_ADDR_PWR 8'h14
`define ILPC_ADDR_STAT 8'h18
`define ILPC_CTRL_GEN_EDGE 0
`define ILPC_CTRL_RX_EDGE 1
`define ILPC_CTRL_TX_EDGE 2
`define ILPC_CTRL_NEST 3
`define ILPC_CTRL_SP2_IRQ 4
`define ILPC_FCLR_CLR_LSB 16
`define ILPC_CMD_ENA 0
`define ILPC_CMD_DIS 1
`define ILPC_CMD_IDLE 2
`define ILPC_CMD_SLOW 3
`define ILPC_CMD_DIV_LSB 4
`define ILPC_CMD_PDOWN 6
`define ILPC_PWR_CTX 0
`define ILPC_PWR_XTAL 1
`define ILPC_PWR_CKODIS 2
`define ILPC_SRC_PWD 0
`define ILPC_SRC_GEN 1
`define ILPC_SRC_LVB 2
`define ILPC_SRC_LVA 3
`define ILPC_SRC_SP0TX 4
`define ILPC_SRC_SP0RX 5
`define ILPC_SRC_EDGE 6
`define ILPC_SRC_BYTE_TRANSFER_ENGINE 7
`define ILPC_SRC_SP1TX 8
`define ILPC_SRC_SP1RX 9
`define ILPC_SRC_TIMER 10
`define ILPC_VEC_RESET 16'h0000
`define ILPC_VEC_PWD 16'h002C
`define ILPC_SLOW_MIN 8'h10
`define ILPC_MASK_RST 10'h000
`define ILPC_CTRL_RST 5'h00
`define ILPC_PWR_RST 3'h0
`endif

//--- dv/ilpc_asserts.sv
// port checker for the interrupt and low power controller
`timescale 1ns/1ps
`default_nettype none
module ilpc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic int_ack,
    input wire logic powerdown_ack,
    input wire logic core_halt,
    input wire logic core_clk_en,
    input wire logic context_clear
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_wait_state_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb wait state wrong");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    slverr_with_ready_a: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    vector_table_a: assert property (int_req |-> int_vector[1:0] == 2'b00 &&
        int_vector >= 16'h0004 && int_vector <= 16'h002C)
        else $error("bad vector");
    ack_drops_req_a: assert property (int_ack && int_req |=> !int_req)
        else $error("request after ack");
    mask_write_block_a: assert property (psel && penable && pready && pwrite &&
        paddr == 32'h0 |=> ##1 !$rose(int_req))
        else $error("request in mask block");
    pdown_ack_halt_a: assert property (powerdown_ack |-> core_halt)
        else $error("ack while running");
    clk_gate_halt_a: assert property (!core_clk_en |-> core_halt)
        else $error("gated outside idle");
    ctx_clear_pulse_a: assert property (context_clear |-> !powerdown_ack ##1 !context_clear)
        else $error("bad context clear");
endmodule

bind ilpc_top ilpc_asserts u_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack),
    .powerdown_ack(powerdown_ack), .core_halt(core_halt), .core_clk_en(core_clk_en),
    .context_clear(context_clear));
`default_nettype wire

//--- dv/ilpc_seq_model.sv
// sequencer model: takes one interrupt at a time and returns after a short handler
`timescale 1ns/1ps
`default_nettype none
module ilpc_seq_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic [3:0] ack_wait,
    output logic int_ack,
    output logic int_return,
    output logic [15:0] status_in,
    output logic [15:0] last_vector,
    output logic [7:0] ack_count
);
    logic [3:0] busy;
    logic [3:0] wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ack <= 1'b0;
            int_return <= 1'b0;
            status_in <= 16'hFFFF;
            last_vector <= 16'h0000;
            ack_count <= 8'h00;
            busy <= 4'h0;
            wait_cnt <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            int_return <= 1'b0;
            // status is only valid at the acknowledge edge, so scramble it afterwards
            if (int_ack) status_in <= ~status_in;
            if (busy != 4'h0) begin
                busy <= busy - 4'h1;
                int_return <= (busy == 4'h1);
            end else if (int_req && wait_cnt < ack_wait) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else if (int_req) begin
                int_ack <= 1'b1;
                status_in <= int_vector ^ 16'h5A5A;
                last_vector <= int_vector;
                ack_count <= ack_count + 8'h01;
                busy <= 4'h6;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/test_interrupt_and_low_power_control.sv
// self-checking bench for the interrupt and low power controller
`timescale 1ns/1ps
`default_nettype none
`include "ilpc_defines.vh"
module test_interrupt_and_low_power_control;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, erv, int_ack, int_return, int_req, powerdown_ack, core_halt;
    logic pin_int_general_n = 1'b1, pin_int_level_a_n = 1'b1, pin_int_level_b_n = 1'b1;
    logic pin_int_edge_n = 1'b1, serial_shared_int_rx_n = 1'b1, serial_shared_int_tx_n = 1'b1;
    logic powerdown_request_pin_n = 1'b1, seq_push = 1'b0, seq_pop = 1'b0;
    logic core_clk_en, context_clear, cycle_clock_output, ctx_seen = 1'b0, prev_clk;
    logic [5:0] evs = 6'h00;
    logic [3:0] ack_wait = 4'h0;
    logic [15:0] status_in, status_out, int_vector, last_vector;
    logic [7:0] ack_count;
    integer fails = 0, check_count = 0, i, n;
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (context_clear === 1'b1) ctx_seen <= 1'b1;

    ilpc_top #(.WAKE_FAST_CYCLES(4), .WAKE_XTAL_CYCLES(8)) DUT (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_int_general_n(pin_int_general_n),
        .pin_int_level_a_n(pin_int_level_a_n), .pin_int_level_b_n(pin_int_level_b_n),
        .pin_int_edge_n(pin_int_edge_n), .serial_shared_int_rx_n(serial_shared_int_rx_n),
        .serial_shared_int_tx_n(serial_shared_int_tx_n),
        .powerdown_request_pin_n(powerdown_request_pin_n), .timer_event(evs[0]),
        .byte_transfer_event(evs[1]), .first_serial_tx_event(evs[2]),
        .first_serial_rx_event(evs[3]), .second_serial_tx_event(evs[4]),
        .second_serial_rx_event(evs[5]), .int_ack(int_ack), .int_return(int_return),
        .seq_push(seq_push), .seq_pop(seq_pop), .status_in(status_in),
        .status_out(status_out), .int_req(int_req), .int_vector(int_vector),
        .powerdown_ack(powerdown_ack), .core_halt(core_halt), .core_clk_en(core_clk_en),
        .context_clear(context_clear), .cycle_clock_output(cycle_clock_output));

    ilpc_seq_model u_seq (.pclk(pclk), .presetn(presetn), .int_req(int_req),
        .int_vector(int_vector), .ack_wait(ack_wait), .int_ack(int_ack),
        .int_return(int_return), .status_in(status_in), .last_vector(last_vector),
        .ack_count(ack_count));

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count = check_count + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k = k + 1;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) fails = fails + 1;
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wait_ack(input logic [15:0] v);
        integer k;
        logic [7:0] c;
        c = ack_count;
        k = 0;
        while (ack_count === c && k < 400) begin
            @(posedge pclk);
            k = k + 1;
        end
        chk("vector", {16'h0, last_vector}, {16'h0, v});
        k = 0;
        while (int_return !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k = k + 1;
        end
        repeat (2) @(posedge pclk);
        chk("popped status", {16'h0, status_out}, {16'h0, v ^ 16'h5A5A});
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        fails = fails + 1;
        finish_test;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset read", rdv, i == 4 ? 32'h1 : i == 6 ? 32'h10 : 32'h0);
            chk("slverr", {31'h0, erv}, {31'h0, i == 7});
        end
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `ILPC_ADDR_CTRL, 32'(i));
            pin_int_general_n <= 1'b0;
            repeat (2) @(posedge pclk);
            pin_int_general_n <= 1'b1;
            repeat (5) @(posedge pclk);
            apb(1'b0, `ILPC_ADDR_PEND, 32'h0);
            chk("general pend", rdv, i == 1 ? 32'h2 : 32'h0);
            apb(1'b1, `ILPC_ADDR_FCLR, 32'h20000);
        end
        pin_int_edge_n <= 1'b0;
        pin_int_level_a_n <= 1'b0;
        repeat (2) @(posedge pclk);
        pin_int_edge_n <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, `ILPC_ADDR_PEND, 32'h0);
        chk("edge and level pend", rdv, 32'h48);
        pin_int_level_a_n <= 1'b1;
        apb(1'b1, `ILPC_ADDR_FCLR, 32'h400000);
        repeat (4) @(posedge pclk);
        apb(1'b0, `ILPC_ADDR_PEND, 32'h0);
        chk("pend cleared", rdv, 32'h0);
        apb(1'b1, `ILPC_ADDR_MASK, 32'h200);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h2);
        apb(1'b1, `ILPC_ADDR_FCLR, 32'h402);
        repeat (6) @(posedge pclk);
        chk("req while disabled", {31'h0, int_req}, 32'h0);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h1);
        wait_ack(16'h0028);
        apb(1'b0, `ILPC_ADDR_PEND, 32'h0);
        chk("masked stays pending", rdv, 32'h2);
        apb(1'b1, `ILPC_ADDR_FCLR, 32'h20000);
        // every source but power-down at once; a slow sequencer must still see strict priority
        ack_wait <= 4'h5;
        apb(1'b1, `ILPC_ADDR_MASK, 32'h3FF);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h2);
        apb(1'b1, `ILPC_ADDR_FCLR, 32'h4E);
        evs <= 6'h3F;
        @(posedge pclk);
        evs <= 6'h00;
        apb(1'b1, `ILPC_ADDR_CMD, 32'h1);
        for (i = 1; i < 11; i++) wait_ack(16'(i * 4));
        ack_wait <= 4'h0;
        apb(1'b1, `ILPC_ADDR_CTRL, 32'h12);
        apb(1'b1, `ILPC_ADDR_MASK, 32'h100);
        serial_shared_int_rx_n <= 1'b0;
        repeat (2) @(posedge pclk);
        serial_shared_int_rx_n <= 1'b1;
        wait_ack(16'h0024);
        apb(1'b1, `ILPC_ADDR_MASK, 32'h0);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h4);
        evs <= 6'h01;
        @(posedge pclk);
        evs <= 6'h00;
        repeat (6) @(posedge pclk);
        chk("idle holds", {31'h0, core_halt}, 32'h1);
        apb(1'b1, `ILPC_ADDR_MASK, 32'h200);
        wait_ack(16'h0028);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `ILPC_ADDR_CMD, 32'hC | 32'(i << 4));
            repeat (2) @(posedge pclk);
            repeat (2) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n = n + 1;
                end while (core_clk_en !== 1'b1 && n < 300);
            end
            chk("slow period", 32'(n), 32'(16 << i));
            evs <= 6'h01;
            @(posedge pclk);
            evs <= 6'h00;
            wait_ack(16'h0028);
        end
        prev_clk = cycle_clock_output;
        @(posedge pclk);
        chk("cycle_clock_output toggles", {31'h0, cycle_clock_output}, {31'h0, ~prev_clk});
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("ce freeze", {31'h0, cycle_clock_output}, {31'h0, prev_clk});
        ce <= 1'b1;
        apb(1'b1, `ILPC_ADDR_PWR, 32'h4);
        repeat (2) @(posedge pclk);
        chk("cycle_clock_output off", {31'h0, cycle_clock_output}, 32'h0);
        apb(1'b1, `ILPC_ADDR_PWR, 32'h1);
        apb(1'b1, `ILPC_ADDR_MASK, 32'h0);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h40);
        repeat (3) @(posedge pclk);
        chk("pdown ack", {31'h0, powerdown_ack}, 32'h1);
        powerdown_request_pin_n <= 1'b0;
        repeat (2) @(posedge pclk);
        powerdown_request_pin_n <= 1'b1;
        wait_ack(16'h002C);
        chk("context clear", {31'h0, ctx_seen}, 32'h1);
        apb(1'b1, `ILPC_ADDR_CMD, 32'h40);
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("reset ends pdown", {31'h0, powerdown_ack}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `ILPC_ADDR_CMD, 32'h0);
        chk("enabled after reset", rdv, 32'h1);
        finish_test;
    end
endmodule
`default_nettype wire
